// file: rtl/fifo_host_pkg.sv
// constants, pin carriers and states for the strobe fifo host controller
package fifo_host_pkg;

  // clock and device timing, nanoseconds, one speed grade
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_WPW_NS = 65;
  localparam int unsigned T_WR_NS = 20;
  localparam int unsigned T_DH_NS = 10;
  localparam int unsigned T_WEF_NS = 60;
  localparam int unsigned T_RPW_NS = 65;
  localparam int unsigned T_A_NS = 65;
  localparam int unsigned T_RR_NS = 20;
  localparam int unsigned T_RFF_NS = 60;
  localparam int unsigned T_RHZ_NS = 35;
  localparam int unsigned T_RS_NS = 65;
  localparam int unsigned T_RSR_NS = 20;

  // least time to whole cycles, never below one
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  function automatic int unsigned max2(input int unsigned a,
                                       input int unsigned b);
    return (a > b) ? a : b;
  endfunction : max2

  // phase lengths in cycles
  localparam int unsigned WR_LOW_CYC = ns_to_cycles(T_WPW_NS);
  localparam int unsigned WR_REC_CYC =
    ns_to_cycles(max2(max2(T_WR_NS, T_DH_NS), T_WEF_NS));
  localparam int unsigned RD_LOW_CYC = ns_to_cycles(max2(T_RPW_NS, T_A_NS));
  localparam int unsigned RD_REC_CYC =
    ns_to_cycles(max2(max2(T_RR_NS, T_RFF_NS), T_RHZ_NS));
  localparam int unsigned CLR_PRE_CYC = ns_to_cycles(max2(T_RPW_NS, T_WPW_NS));
  localparam int unsigned CLR_LOW_CYC = ns_to_cycles(T_RS_NS);
  localparam int unsigned CLR_POST_CYC = ns_to_cycles(max2(T_RS_NS, T_RSR_NS));

  // timer loads: a load of n-1 gives a phase of n cycles
  localparam int unsigned TIMER_W = 8;
  localparam logic [7:0] WR_LOW_CNT = 8'(WR_LOW_CYC - 1);
  localparam logic [7:0] WR_REC_CNT = 8'(WR_REC_CYC - 1);
  localparam logic [7:0] RD_LOW_CNT = 8'(RD_LOW_CYC - 1);
  localparam logic [7:0] RD_REC_CNT = 8'(RD_REC_CYC - 1);
  localparam logic [7:0] CLR_PRE_CNT = 8'(CLR_PRE_CYC - 1);
  localparam logic [7:0] CLR_LOW_CNT = 8'(CLR_LOW_CYC - 1);
  localparam logic [7:0] CLR_POST_CNT = 8'(CLR_POST_CYC - 1);

  // device geometry
  localparam int unsigned DATA_W = 9;
  localparam int unsigned SMALL_DEPTH = 2048;
  localparam int unsigned LARGE_DEPTH = 4096;
  localparam int unsigned FILL_W = 13;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] WDATA_OFF = 8'h04;
  localparam logic [7:0] RDATA_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;

  // control bits
  localparam int unsigned CTRL_CLEAR_BIT = 0;
  localparam int unsigned CTRL_READ_BIT = 1;

  // status bits
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_NO_DATA_BIT = 1;
  localparam int unsigned ST_NO_ROOM_BIT = 2;
  localparam int unsigned ST_CLEARED_BIT = 3;
  localparam int unsigned ST_RD_VALID_BIT = 4;
  localparam int unsigned ST_WR_REF_BIT = 8;
  localparam int unsigned ST_RD_REF_BIT = 9;
  localparam int unsigned ST_BUSY_REF_BIT = 10;
  localparam int unsigned ST_FILL_LSB = 16;

  // pins driven towards the device
  typedef struct packed {
    logic pointer_clear_in_n;
    logic write_n;
    logic read_n;
    logic [DATA_W-1:0] wdata;
  } pin_out_type;

  // pins returned by the device
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic no_data_flag_n;
    logic no_room_flag_n;
  } pin_in_type;

  localparam pin_out_type PIN_IDLE = '{1'b1, 1'b1, 1'b1, 9'h000};

  // sequencer states, one-hot
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_CLR_PRE = 9'h002,
    S_CLR_LOW = 9'h004,
    S_CLR_POST = 9'h008,
    S_WR_LOW = 9'h010,
    S_WR_REC = 9'h020,
    S_RD_LOW = 9'h040,
    S_RD_REC = 9'h080,
    S_SPARE = 9'h100
  } state_type;

endpackage : fifo_host_pkg

// file: rtl/pin_timer.sv
// down-counter that times one strobe or clear phase
`timescale 1ns/1ps
module pin_timer (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // load and status
  input wire logic load_i,
  input wire logic [fifo_host_pkg::TIMER_W-1:0] count_i,
  output logic done_o
);

  localparam logic [fifo_host_pkg::TIMER_W-1:0] STEP =
    {{(fifo_host_pkg::TIMER_W-1){1'b0}}, 1'b1};

  logic [fifo_host_pkg::TIMER_W-1:0] cnt_q;

  // load wins, otherwise count down to zero and rest there
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else if (ce_i)
    begin
      if (load_i)
        cnt_q <= count_i;
      else if (cnt_q != '0)
        cnt_q <= cnt_q - STEP;
    end
  end

  assign done_o = (cnt_q == '0);

endmodule : pin_timer

// file: rtl/fifo_host.sv
// host controller driving a strobe fifo through its pins, wishbone registers
// Behaviour
// [R1] words are nine bits each way
// [R2] device holds 2K or 4K words
// [R3] no address; device pointers sequence words
// [R4] writes and reads run independently; here one sequencer runs them one at a time and refuses a command while busy
// [R5] flags guard overflow and underflow
// [R6] clear low resets both pointers
// [R7] clear drives no-data flag low
// [R8] clear must precede the first write
// [R9] strobes high around clear rising edge
// [R10] write starts on strobe fall if room
// [R11] data stable around write strobe rise
// [R12] each word goes to next location
// [R13] no-room flag low refuses writes
// [R14] read on full restores room flag
// [R15] full device ignores write strobe
// [R16] strobes must be glitch free
// [R17] no pulse shorter than minimum width
// [R18] read starts on strobe fall if data
// [R19] last read drives no-data flag low
// [R20] full after 2048 or 4096 writes
// [R21] single device, no cascading
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module fifo_host (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device pins
  output fifo_host_pkg::pin_out_type pin_o,
  input wire fifo_host_pkg::pin_in_type pin_i
);

  fifo_host_pkg::state_type state_q;
  fifo_host_pkg::state_type state_d;
  fifo_host_pkg::pin_out_type pin_q;
  fifo_host_pkg::pin_out_type pin_d;
  logic ack_q;
  logic [31:0] dat_q;
  logic [fifo_host_pkg::DATA_W-1:0] rdata_q;
  logic rd_valid_q;
  logic cleared_q;
  logic wr_ref_q;
  logic rd_ref_q;
  logic busy_ref_q;
  logic [fifo_host_pkg::FILL_W-1:0] fill_q; // [R2] wide enough for 4096
  logic load;
  logic [fifo_host_pkg::TIMER_W-1:0] load_cnt;
  logic done;
  logic capture;
  logic wr_end;
  logic clr_end;

  // bus request and address decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_req = req & wb_we_i;
  wire rd_req = req & ~wb_we_i;
  wire hit_ctrl = (wb_adr_i == fifo_host_pkg::CTRL_OFF);
  wire hit_wdata = (wb_adr_i == fifo_host_pkg::WDATA_OFF);
  wire hit_rdata = (wb_adr_i == fifo_host_pkg::RDATA_OFF);
  wire hit_status = (wb_adr_i == fifo_host_pkg::STATUS_OFF);

  // command requests from software
  wire go_clear = wr_req & hit_ctrl & wb_sel_i[0] &
                  wb_dat_i[fifo_host_pkg::CTRL_CLEAR_BIT];
  wire go_read = wr_req & hit_ctrl & wb_sel_i[0] &
                 wb_dat_i[fifo_host_pkg::CTRL_READ_BIT] & ~go_clear;
  wire go_write = wr_req & hit_wdata & (&wb_sel_i[1:0]); // [R3] data only
  wire idle = (state_q == fifo_host_pkg::S_IDLE);

  // acceptance: flags gate each strobe before it falls
  wire room_ok = pin_i.no_room_flag_n; // [R13] [R15]
  wire data_ok = pin_i.no_data_flag_n; // [R19]
  wire start_clear = go_clear & idle;
  wire start_write = go_write & idle & cleared_q & room_ok; // [R8] [R10] [R5]
  wire start_read = go_read & idle & data_ok; // [R18] [R5]
  wire wr_refuse = go_write & idle & ~(cleared_q & room_ok);
  wire rd_refuse = go_read & idle & ~data_ok;
  wire busy_refuse = (go_clear | go_read | go_write) & ~idle;

  // sticky-bit clears by writing ones to status
  wire st_clr = wr_req & hit_status & wb_sel_i[1];
  wire clr_wr_ref = st_clr & wb_dat_i[fifo_host_pkg::ST_WR_REF_BIT];
  wire clr_rd_ref = st_clr & wb_dat_i[fifo_host_pkg::ST_RD_REF_BIT];
  wire clr_busy_ref = st_clr & wb_dat_i[fifo_host_pkg::ST_BUSY_REF_BIT];

  // status word
  wire [31:0] status_word = {3'h0, fill_q, 5'h00, busy_ref_q, rd_ref_q,
                             wr_ref_q, 3'h0, rd_valid_q, cleared_q,
                             pin_i.no_room_flag_n, pin_i.no_data_flag_n,
                             ~idle};

  // read data selection, unmapped reads as zero
  wire [31:0] rd_mux = hit_ctrl ? 32'h0000_0000 :
                       hit_wdata ? {23'h000000, pin_q.wdata} :
                       hit_rdata ? {23'h000000, rdata_q} :
                       hit_status ? status_word : 32'h0000_0000;

  // phase timer
  pin_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(load),
    .count_i(load_cnt),
    .done_o(done)
  );

  // sequencer: every strobe edge comes from a flop, so no glitches [R16]
  always_comb
  begin
    state_d = state_q;
    pin_d = pin_q;
    load = 1'b0;
    load_cnt = '0;
    capture = 1'b0;
    wr_end = 1'b0;
    clr_end = 1'b0;
    case (state_q)
      fifo_host_pkg::S_IDLE:
      begin
        if (start_clear)
        begin
          // strobes already high; hold them so before clear [R9]
          load = 1'b1;
          load_cnt = fifo_host_pkg::CLR_PRE_CNT;
          state_d = fifo_host_pkg::S_CLR_PRE;
        end
        else if (start_write)
        begin
          pin_d.wdata = wb_dat_i[fifo_host_pkg::DATA_W-1:0]; // [R1]
          pin_d.write_n = 1'b0; // [R10]
          load = 1'b1;
          load_cnt = fifo_host_pkg::WR_LOW_CNT; // [R17]
          state_d = fifo_host_pkg::S_WR_LOW;
        end
        else if (start_read)
        begin
          pin_d.read_n = 1'b0; // [R18]
          load = 1'b1;
          load_cnt = fifo_host_pkg::RD_LOW_CNT; // [R17]
          state_d = fifo_host_pkg::S_RD_LOW;
        end
      end
      fifo_host_pkg::S_CLR_PRE:
      begin
        if (done)
        begin
          pin_d.pointer_clear_in_n = 1'b0; // [R6] [R7]
          load = 1'b1;
          load_cnt = fifo_host_pkg::CLR_LOW_CNT; // [R17]
          state_d = fifo_host_pkg::S_CLR_LOW;
        end
      end
      fifo_host_pkg::S_CLR_LOW:
      begin
        if (done)
        begin
          pin_d.pointer_clear_in_n = 1'b1;
          load = 1'b1;
          load_cnt = fifo_host_pkg::CLR_POST_CNT; // [R9]
          state_d = fifo_host_pkg::S_CLR_POST;
        end
      end
      fifo_host_pkg::S_CLR_POST:
      begin
        if (done)
        begin
          clr_end = 1'b1;
          state_d = fifo_host_pkg::S_IDLE;
        end
      end
      fifo_host_pkg::S_WR_LOW:
      begin
        if (done)
        begin
          // device latches the word on this rising edge [R11] [R12]
          pin_d.write_n = 1'b1;
          wr_end = 1'b1;
          load = 1'b1;
          load_cnt = fifo_host_pkg::WR_REC_CNT;
          state_d = fifo_host_pkg::S_WR_REC;
        end
      end
      fifo_host_pkg::S_WR_REC:
      begin
        // data held through recovery covers hold time [R11]
        if (done)
          state_d = fifo_host_pkg::S_IDLE;
      end
      fifo_host_pkg::S_RD_LOW:
      begin
        if (done)
        begin
          pin_d.read_n = 1'b1;
          capture = 1'b1;
          load = 1'b1;
          load_cnt = fifo_host_pkg::RD_REC_CNT; // [R14]
          state_d = fifo_host_pkg::S_RD_REC;
        end
      end
      fifo_host_pkg::S_RD_REC:
      begin
        if (done)
          state_d = fifo_host_pkg::S_IDLE;
      end
      default:
      begin
        pin_d = fifo_host_pkg::PIN_IDLE;
        state_d = fifo_host_pkg::S_IDLE;
      end
    endcase
  end

  // state and pin flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= fifo_host_pkg::S_IDLE;
      pin_q <= fifo_host_pkg::PIN_IDLE;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      pin_q <= pin_d;
    end
  end

  // bus answer one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_q <= req;
      dat_q <= rd_req ? rd_mux : 32'h0000_0000;
    end
  end

  // captured word and its valid flag, set wins over a new read start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (capture)
        rdata_q <= pin_i.rdata; // [R1]
      rd_valid_q <= capture | (rd_valid_q & ~start_read);
    end
  end

  // sticky refusals, an event beats a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ref_q <= 1'b0;
      rd_ref_q <= 1'b0;
      busy_ref_q <= 1'b0;
    end
    else if (ce_i)
    begin
      wr_ref_q <= wr_refuse | (wr_ref_q & ~clr_wr_ref); // [R8] [R13]
      rd_ref_q <= rd_refuse | (rd_ref_q & ~clr_rd_ref); // [R19]
      busy_ref_q <= busy_refuse | (busy_ref_q & ~clr_busy_ref);
    end
  end

  // cleared-once flag and word count kept by the host
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cleared_q <= 1'b0;
      fill_q <= '0;
    end
    else if (ce_i)
    begin
      if (clr_end)
        cleared_q <= 1'b1; // [R8]
      if (clr_end)
        fill_q <= '0; // [R6]
      else if (wr_end)
        fill_q <= fill_q + 13'h0001; // [R12] [R20]
      else if (capture)
        fill_q <= fill_q - 13'h0001; // [R4]
    end
  end

  // outputs straight from flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign pin_o = pin_q; // [R21] no chain pins, single device

endmodule : fifo_host

// file: verification/fifo_host_checker.sv
// assertion checker for the strobe fifo host controller
`timescale 1ns/1ps
module fifo_host_checker (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // device pins
  input wire fifo_host_pkg::pin_out_type pin_o,
  input wire fifo_host_pkg::pin_in_type pin_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);
  // bus answer timing
  ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
    |=> wb_ack_o) else $error("bus request not answered next cycle");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // pins quiet right after reset
  reset_idle_a: assert property ($fell(rst_i) |-> pin_o.write_n &&
    pin_o.read_n && pin_o.pointer_clear_in_n && !wb_ack_o)
    else $error("pins or ack not idle after reset");
  // strobes only start with the matching flag high
  write_room_a: assert property ($fell(pin_o.write_n) |->
    $past(pin_i.no_room_flag_n)) else $error("write started while full");
  read_data_a: assert property ($fell(pin_o.read_n) |->
    $past(pin_i.no_data_flag_n)) else $error("read started while empty");
  // pulse widths, no short glitches
  write_pulse_a: assert property ($fell(pin_o.write_n) |=>
    (!pin_o.write_n)[*8] ##9 $rose(pin_o.write_n))
    else $error("write strobe width wrong");
  read_pulse_a: assert property ($fell(pin_o.read_n) |=>
    (!pin_o.read_n)[*8] ##9 $rose(pin_o.read_n))
    else $error("read strobe width wrong");
  clear_pulse_a: assert property ($fell(pin_o.pointer_clear_in_n) |=>
    (!pin_o.pointer_clear_in_n)[*8] ##9 $rose(pin_o.pointer_clear_in_n))
    else $error("clear pulse width wrong");
  // data held around the write strobe
  data_low_a: assert property (!pin_o.write_n && !$fell(pin_o.write_n)
    |-> $stable(pin_o.wdata)) else $error("write data moved while low");
  data_hold_a: assert property ($rose(pin_o.write_n) |->
    ($stable(pin_o.wdata))[*3]) else $error("write data hold too short");
  // strobes high during clear, write strobe high after it
  clear_quiet_a: assert property (!pin_o.pointer_clear_in_n |->
    pin_o.write_n && pin_o.read_n) else $error("strobe low during clear");
  clear_after_a: assert property ($rose(pin_o.pointer_clear_in_n) |->
    (pin_o.write_n)[*8]) else $error("write strobe moved after clear");
  // main scenarios
  write_seen_c: cover property ($fell(pin_o.write_n));
  read_seen_c: cover property ($fell(pin_o.read_n));
  clear_seen_c: cover property ($fell(pin_o.pointer_clear_in_n));
  full_seen_c: cover property ($fell(pin_i.no_room_flag_n));
endmodule : fifo_host_checker

bind fifo_host fifo_host_checker u_fifo_host_checker (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pin_o(pin_o), .pin_i(pin_i));

// file: verification/fifo_dev_model.sv
// behavioural strobe fifo device seen by the host controller
`timescale 1ns/1ps
module fifo_dev_model #(
  parameter int unsigned DEPTH = fifo_host_pkg::SMALL_DEPTH
) (
  // strobes and data from the host
  input wire fifo_host_pkg::pin_out_type pin_i,
  // flags and data to the host
  output fifo_host_pkg::pin_in_type pin_o
);
  logic [8:0] mem [DEPTH];
  int unsigned wr_ptr = 5; // garbage until the first clear
  int unsigned rd_ptr = 0;
  int unsigned level = 5;
  logic wr_ok = 1'b0;
  logic rd_ok = 1'b0;
  logic [8:0] last_q = 9'h0A5;
  // clear: pointers to the first location, empty
  always @(negedge pin_i.pointer_clear_in_n)
  begin
    wr_ptr = 0;
    rd_ptr = 0;
    level = 0;
  end
  // write starts on the fall only with room; full ignores
  always @(negedge pin_i.write_n)
    wr_ok = pin_i.pointer_clear_in_n && (level < DEPTH);
  // word taken at the rise, next location, no address
  always @(posedge pin_i.write_n)
    if (wr_ok)
    begin
      mem[wr_ptr % DEPTH] = pin_i.wdata;
      wr_ptr = wr_ptr + 1;
      level = level + 1;
      wr_ok = 1'b0;
    end
  // read runs on its own strobe, only with data
  always @(negedge pin_i.read_n)
    rd_ok = pin_i.pointer_clear_in_n && (level > 0);
  always @(posedge pin_i.read_n)
    if (rd_ok)
    begin
      last_q = mem[rd_ptr % DEPTH];
      rd_ptr = rd_ptr + 1;
      level = level - 1;
      rd_ok = 1'b0;
    end
  // released bus shows the inverse of the last word; single device
  assign pin_o = {(!pin_i.read_n && rd_ok) ? mem[rd_ptr % DEPTH] : ~last_q,
    level != 0, level < DEPTH};
endmodule : fifo_dev_model

// file: verification/fifo_host_test.sv
// self-checking bench for the strobe fifo host controller
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module fifo_host_test;
  localparam int unsigned DEPTH = 16;
  localparam logic [7:0] CT = fifo_host_pkg::CTRL_OFF;
  localparam logic [7:0] WD = fifo_host_pkg::WDATA_OFF;
  localparam logic [7:0] RD = fifo_host_pkg::RDATA_OFF;
  localparam logic [7:0] ST = fifo_host_pkg::STATUS_OFF;
  localparam logic [31:0] MASK = 32'h1FFF000E;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h00000000;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  fifo_host_pkg::pin_out_type host_pins;
  fifo_host_pkg::pin_in_type dev_pins;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  fifo_host u_fifo_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .pin_o(host_pins),
    .pin_i(dev_pins));
  fifo_dev_model #(.DEPTH(DEPTH)) u_fifo_dev_model (.pin_i(host_pins),
    .pin_o(dev_pins));
  // clock, 4 ns period
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  // expected status flags, clear marker and word count
  function automatic logic [31:0] exp_st(input logic e_n, input logic f_n,
                                         input int unsigned n);
    logic [31:0] v;
    v = 32'h00000000;
    v[fifo_host_pkg::ST_NO_DATA_BIT] = e_n;
    v[fifo_host_pkg::ST_NO_ROOM_BIT] = f_n;
    v[fifo_host_pkg::ST_CLEARED_BIT] = 1'b1;
    v[fifo_host_pkg::ST_FILL_LSB +: 13] = 13'(n);
    return v;
  endfunction : exp_st
  // one classic wishbone cycle, waits for ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_w <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, 4'hF, q);
  endtask : rd
  // poll status until the pin sequencer is idle
  task automatic idle(output logic [31:0] st);
    do rd(ST, st); while (st[fifo_host_pkg::ST_BUSY_BIT] !== 1'b0);
  endtask : idle
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fail_count++;
      close_out();
    end
  end
  // main sequence
  initial
  begin
    logic [31:0] st;
    logic [31:0] q;
    logic [8:0] w;
    logic [8:0] exp_q[$];
    void'($urandom(61));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // write before any clear is refused
    wr(WD, 32'h00000155, 4'h3);
    idle(st);
    `CHK(st[fifo_host_pkg::ST_WR_REF_BIT], 1'b1)
    `CHK(st[fifo_host_pkg::ST_CLEARED_BIT], 1'b0)
    $display("test no_clear done");
    // clear: empty flag low, full flag high, count zero
    wr(CT, 32'h00000001, 4'h1);
    idle(st);
    `CHK(st & MASK, exp_st(1'b0, 1'b1, 0))
    wr(ST, 32'h00000700, 4'h2);
    wr(CT, 32'h00000002, 4'h1);
    idle(st);
    `CHK(st[9:8], 2'b10)
    wr(ST, 32'h00000700, 4'h2);
    $display("test clear done");
    // fill with random words, extremes first
    for (int i = 0; i < DEPTH; i++)
    begin
      w = (i == 0) ? 9'h1FF : (i == 1) ? 9'h000 : 9'($urandom);
      exp_q.push_back(w);
      wr(WD, {23'h000000, w}, 4'h3);
      idle(st);
    end
    `CHK(st & MASK, exp_st(1'b1, 1'b0, DEPTH))
    wr(WD, 32'h000000AA, 4'h3);
    idle(st);
    `CHK(st[fifo_host_pkg::ST_WR_REF_BIT], 1'b1)
    `CHK(st & MASK, exp_st(1'b1, 1'b0, DEPTH))
    $display("test fill done");
    // one read frees room, next write refills
    wr(CT, 32'h00000002, 4'h1);
    idle(st);
    `CHK(st[fifo_host_pkg::ST_NO_ROOM_BIT], 1'b1)
    w = 9'($urandom);
    exp_q.push_back(w);
    wr(WD, {23'h000000, w}, 4'h3);
    idle(st);
    `CHK(st[fifo_host_pkg::ST_NO_ROOM_BIT], 1'b0)
    rd(RD, q);
    w = exp_q.pop_front();
    `CHK(q[8:0], w)
    // drain in order
    while (exp_q.size() > 0)
    begin
      wr(CT, 32'h00000002, 4'h1);
      idle(st);
      rd(RD, q);
      w = exp_q.pop_front();
      `CHK(q[8:0], w)
    end
    `CHK(st & MASK, exp_st(1'b0, 1'b1, 0))
    $display("test drain done");
    // clear with a word stored, then a fresh word reads back
    wr(WD, 32'h00000033, 4'h3);
    idle(st);
    wr(CT, 32'h00000001, 4'h1);
    idle(st);
    `CHK(st & MASK, exp_st(1'b0, 1'b1, 0))
    wr(WD, 32'h00000112, 4'h3);
    // enable low mid-strobe freezes the pins, then a busy command is refused
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    `CHK(host_pins.write_n, 1'b0)
    ce_i <= 1'b1;
    wr(CT, 32'h00000002, 4'h1);
    idle(st);
    `CHK(st[fifo_host_pkg::ST_BUSY_REF_BIT], 1'b1)
    idle(st);
    wr(CT, 32'h00000002, 4'h1);
    idle(st);
    rd(RD, q);
    `CHK(q[8:0], 9'h112)
    rd(8'h10, q);
    `CHK(q, 32'h00000000)
    $display("test reclear done");
    close_out();
  end
endmodule : fifo_host_test
